// ### rtl/resolver_port_device.sv
// Converter end of the host port: parallel and serial access to sampled results.
`timescale 1ns/1ps
`default_nettype none
`include "resolver_port_map.svh"

// How it works
// - Respond only while device select is low
// - Port select low serial, high parallel
// - Parallel outputs driven only during select and read
// - Host keeps read strobe high in serial
// - Parallel write takes low byte during strobe
// - Frame strobe with select frames serial transfers
// - Sample falling edge latches position, velocity, faults
// - Serial output bit changes on clock rise
// - Serial input bit captured on clock fall
// - Host drives serial clock on bit 13
// - Bits 15 to 8 are output only in parallel
// - Bits 7 to 0 are bidirectional
// - Encoder A runs freely, valid with signals
// - Master clock between 6.144 and 10.24 MHz
// - Resolution pins jointly pick resolution
// - Mode pins jointly pick operating mode
// - Mode held 24 or 16 clocks in readback
module resolver_port_device (
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic          ce_i,
    resolver_port_if.device    link,
    input  wire logic [15:0]   position_i,
    input  wire logic [15:0]   velocity_i,
    input  wire logic [7:0]    fault_i,
    input  wire logic          signals_valid_i,
    output logic      [7:0]    config_data_o,
    output logic               config_valid_o,
    output logic      [1:0]    resolution_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    localparam int SYNC_W = 19;

    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] prev_reg;

    assign pin_raw = {link.port_select, link.sample_n, link.device_select_n,
                      link.read_strobe_n, link.write_frame_strobe_n,
                      link.mode_pin_hi, link.mode_pin_lo,
                      link.resolution_select_hi, link.resolution_select_lo,
                      link.data_bus[14], link.data_bus[13], link.data_bus[7:0]};

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            prev_reg  <= '1;
        end else if (ce_i) begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded pin levels and edges.

    wire       psel      = sync2_reg[18];
    wire       smp_n     = sync2_reg[17];
    wire       cs_n      = sync2_reg[16];
    wire       rd_n      = sync2_reg[15];
    wire       wr_n      = sync2_reg[14];
    wire [1:0] mode      = sync2_reg[13:12];
    wire [1:0] res_sel   = sync2_reg[11:10];
    wire       sdi       = sync2_reg[9];
    wire       sclk      = sync2_reg[8];
    wire [7:0] din       = sync2_reg[7:0];

    wire       psel_p    = prev_reg[18];
    wire       smp_n_p   = prev_reg[17];
    wire       cs_n_p    = prev_reg[16];
    wire       wr_n_p    = prev_reg[14];
    wire       sclk_p    = prev_reg[8];

    wire       selected    = ~cs_n;
    wire       par_rd      = psel & selected & ~rd_n;
    wire       par_wr      = psel & selected & ~wr_n;
    wire       par_wr_p    = psel_p & ~cs_n_p & ~wr_n_p;
    // read strobe is ignored entirely while the serial port is chosen.
    wire       frame       = ~psel & selected & ~wr_n;
    wire       frame_p     = ~psel_p & ~cs_n_p & ~wr_n_p;
    wire       frame_start = frame & ~frame_p;
    wire       frame_end   = ~frame & frame_p;
    wire       sclk_rise   = frame & sclk & ~sclk_p;
    wire       sclk_fall   = frame & ~sclk & sclk_p;
    wire       sample_fall = ~smp_n & smp_n_p;
    wire       par_wr_end  = par_wr_p & ~par_wr;

    ////////////////////////////////////////////////////////////////////////////
    // Sampled result registers.

    logic [15:0] position_reg;
    logic [15:0] velocity_reg;
    logic [7:0]  fault_reg;
    logic [7:0]  cfg_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            position_reg <= 16'h0000;
            velocity_reg <= 16'h0000;
            fault_reg    <= 8'h00;
        end else if (ce_i && sample_fall) begin
            position_reg <= position_i;
            velocity_reg <= velocity_i;
            fault_reg    <= fault_i;
        end
    end

    // the mode pins pick which word a read or a frame returns.
    wire [15:0] out_word = (mode == `RSP_MODE_VELOCITY) ? velocity_reg :
                           (mode == `RSP_MODE_CONFIG)   ? {8'h00, cfg_reg} :
                           position_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial shifters.

    logic [23:0] out_shift_reg;
    logic [7:0]  in_shift_reg;
    logic [4:0]  in_cnt_reg;
    logic [7:0]  wr_hold_reg;

    // the 16 data bits go first and the fault byte follows.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            out_shift_reg <= 24'h000000;
        end else if (ce_i) begin
            if (frame_start) begin
                out_shift_reg <= {out_word, fault_reg};
            end else if (sclk_rise) begin
                out_shift_reg <= {out_shift_reg[22:0], 1'b0};
            end
        end
    end

    // The bit count saturates so that long frames cannot wrap into a short one.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            in_shift_reg <= 8'h00;
            in_cnt_reg   <= 5'h00;
        end else if (ce_i) begin
            if (frame_start) begin
                in_cnt_reg <= 5'h00;
            end else if (sclk_fall) begin
                in_shift_reg <= {in_shift_reg[6:0], sdi};
                if (in_cnt_reg != 5'h1F) begin
                    in_cnt_reg <= in_cnt_reg + 5'h01;
                end
            end
        end
    end

    // The strobe edge is seen a cycle late, so the byte held while it was low is kept.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_hold_reg <= 8'h00;
        end else if (ce_i && par_wr) begin
            wr_hold_reg <= din;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration byte delivered to the core.

    wire ser_cfg = frame_end && (in_cnt_reg >= 5'(`RSP_CFG_BITS));
    wire cfg_wr  = par_wr_end || ser_cfg;
    wire [7:0] cfg_next = par_wr_end ? wr_hold_reg : in_shift_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_reg        <= 8'h00;
            config_data_o  <= 8'h00;
            config_valid_o <= 1'b0;
        end else if (ce_i) begin
            config_valid_o <= cfg_wr;
            if (cfg_wr) begin
                cfg_reg       <= cfg_next;
                config_data_o <= cfg_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    wire [15:0] oe_n_next = {~(par_rd | frame), {15{~par_rd}}};

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            link.dev_data_oe_n <= 16'hFFFF;
            link.dev_data_out  <= 16'h0000;
        end else if (ce_i) begin
            link.dev_data_oe_n <= oe_n_next;
            if (par_rd) begin
                link.dev_data_out <= out_word;
            end else if (sclk_rise) begin
                link.dev_data_out <= {out_shift_reg[23], 15'h0000};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Encoder output and resolution strap.

    // Quadrature A follows the angle itself and freezes while the inputs are bad.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            link.enc_a   <= 1'b0;
            resolution_o <= 2'h0;
        end else if (ce_i) begin
            if (signals_valid_i) begin
                link.enc_a <= position_i[1];
            end
            resolution_o <= res_sel;
        end
    end

endmodule

`default_nettype wire

// ### rtl/resolver_port_host.sv
// Host end of the converter port: sequences parallel and serial transfers.
`timescale 1ns/1ps
`default_nettype none
`include "resolver_port_map.svh"

module resolver_port_host (
    input  wire logic                       clk_i,
    input  wire logic                       reset_i,
    input  wire logic                       ce_i,
    resolver_port_if.host                   link,
    input  wire logic                       port_select_i,
    input  wire logic [1:0]                 resolution_i,
    input  wire logic                       start_i,
    input  wire resolver_port_pkg::cmd_kind_t kind_i,
    input  wire logic [1:0]                 mode_i,
    input  wire logic [7:0]                 wdata_i,
    input  wire logic                       with_fault_i,
    input  wire logic                       sample_i,
    output logic                            busy_o,
    output logic                            done_o,
    output logic      [23:0]                rdata_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus synchroniser and sequencer state.

    logic [15:0]                   bus1_reg;
    logic [15:0]                   bus2_reg;
    resolver_port_pkg::host_state_t state_reg;
    resolver_port_pkg::cmd_kind_t   kind_reg;
    logic [4:0]                    wait_reg;
    logic [4:0]                    bit_reg;
    logic [4:0]                    bits_total_reg;
    logic [7:0]                    sdi_shift_reg;
    logic [23:0]                   sdo_shift_reg;
    logic [2:0]                    smp_cnt_reg;

    wire wait_done = (wait_reg == 5'h00);
    wire is_serial = (kind_reg == resolver_port_pkg::CMD_SERIAL);
    wire last_bit  = (bit_reg == bits_total_reg - 5'h01);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bus1_reg <= 16'hFFFF;
            bus2_reg <= 16'hFFFF;
        end else if (ce_i) begin
            bus1_reg <= link.data_bus;
            bus2_reg <= bus1_reg;
        end
    end

    // Sample pulse is stretched so that the converter's synchroniser sees it.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            smp_cnt_reg   <= 3'h0;
            link.sample_n <= 1'b1;
        end else if (ce_i) begin
            if (sample_i && smp_cnt_reg == 3'h0) begin
                smp_cnt_reg   <= 3'(`RSP_SAMPLE_CYC);
                link.sample_n <= 1'b0;
            end else if (smp_cnt_reg != 3'h0) begin
                smp_cnt_reg   <= smp_cnt_reg - 3'h1;
                link.sample_n <= (smp_cnt_reg == 3'h1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer.

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg                 <= resolver_port_pkg::ST_IDLE;
            kind_reg                  <= resolver_port_pkg::CMD_PAR_READ;
            wait_reg                  <= 5'h00;
            bit_reg                   <= 5'h00;
            bits_total_reg            <= 5'h00;
            sdi_shift_reg             <= 8'h00;
            sdo_shift_reg             <= 24'h000000;
            link.device_select_n      <= 1'b1;
            link.read_strobe_n        <= 1'b1;
            link.write_frame_strobe_n <= 1'b1;
            link.port_select          <= 1'b1;
            link.mode_pin_lo          <= 1'b0;
            link.mode_pin_hi          <= 1'b0;
            link.resolution_select_lo <= 1'b0;
            link.resolution_select_hi <= 1'b0;
            link.host_data_out        <= 16'h0000;
            link.host_data_oe_n       <= 16'hFFFF;
            busy_o                    <= 1'b0;
            done_o                    <= 1'b0;
            rdata_o                   <= 24'h000000;
        end else if (ce_i) begin
            done_o <= 1'b0;
            link.resolution_select_hi <= resolution_i[1];
            link.resolution_select_lo <= resolution_i[0];
            if (!wait_done) begin
                wait_reg <= wait_reg - 5'h01;
            end
            case (state_reg)
                resolver_port_pkg::ST_IDLE: begin
                    link.port_select <= port_select_i;
                    if (start_i) begin
                        kind_reg             <= kind_i;
                        link.port_select     <= (kind_i != resolver_port_pkg::CMD_SERIAL);
                        {link.mode_pin_hi, link.mode_pin_lo} <= mode_i;
                        sdi_shift_reg        <= wdata_i;
                        bits_total_reg       <= with_fault_i ? 5'(`RSP_FRAME_BITS)
                                                             : 5'(`RSP_DATA_BITS);
                        bit_reg              <= 5'h00;
                        sdo_shift_reg        <= 24'h000000;
                        link.device_select_n <= 1'b0;
                        busy_o               <= 1'b1;
                        wait_reg             <= 5'(`RSP_SETUP_CYC - 1);
                        state_reg            <= resolver_port_pkg::ST_SETUP;
                    end
                end
                resolver_port_pkg::ST_SETUP: begin
                    if (wait_done) begin
                        wait_reg  <= 5'(`RSP_ACCESS_CYC - 1);
                        state_reg <= resolver_port_pkg::ST_ACCESS;
                        case (kind_reg)
                            resolver_port_pkg::CMD_PAR_READ: begin
                                link.read_strobe_n <= 1'b0;
                            end
                            resolver_port_pkg::CMD_PAR_WRITE: begin
                                link.host_data_out  <= {8'h00, sdi_shift_reg};
                                link.host_data_oe_n <= 16'hFF00;
                                link.write_frame_strobe_n <= 1'b0;
                            end
                            default: begin
                                link.host_data_out  <= {1'b0, sdi_shift_reg[7], 14'h0000};
                                link.host_data_oe_n <= 16'h9FFF;
                                link.write_frame_strobe_n <= 1'b0;
                            end
                        endcase
                    end
                end
                resolver_port_pkg::ST_ACCESS: begin
                    if (wait_done) begin
                        if (is_serial) begin
                            link.host_data_out[13] <= 1'b1;
                            wait_reg  <= 5'(`RSP_SCLK_HALF_CYC - 1);
                            state_reg <= resolver_port_pkg::ST_RISE;
                        end else begin
                            if (kind_reg == resolver_port_pkg::CMD_PAR_READ) begin
                                rdata_o <= {8'h00, bus2_reg};
                            end
                            link.read_strobe_n        <= 1'b1;
                            link.write_frame_strobe_n <= 1'b1;
                            wait_reg  <= 5'(`RSP_RELEASE_CYC - 1);
                            state_reg <= resolver_port_pkg::ST_RELEASE;
                        end
                    end
                end
                resolver_port_pkg::ST_RISE: begin
                    if (wait_done) begin
                        sdo_shift_reg <= {sdo_shift_reg[22:0], bus2_reg[15]};
                        link.host_data_out[13] <= 1'b0;
                        wait_reg  <= 5'(`RSP_SCLK_HALF_CYC - 1);
                        state_reg <= resolver_port_pkg::ST_FALL;
                    end
                end
                resolver_port_pkg::ST_FALL: begin
                    if (wait_done) begin
                        bit_reg  <= bit_reg + 5'h01;
                        wait_reg <= 5'(`RSP_SCLK_HALF_CYC - 1);
                        if (last_bit) begin
                            rdata_o <= sdo_shift_reg;
                            link.write_frame_strobe_n <= 1'b1;
                            wait_reg  <= 5'(`RSP_RELEASE_CYC - 1);
                            state_reg <= resolver_port_pkg::ST_RELEASE;
                        end else begin
                            sdi_shift_reg <= {sdi_shift_reg[6:0], 1'b0};
                            link.host_data_out[14] <= sdi_shift_reg[6];
                            link.host_data_out[13] <= 1'b1;
                            state_reg <= resolver_port_pkg::ST_RISE;
                        end
                    end
                end
                resolver_port_pkg::ST_RELEASE: begin
                    link.host_data_oe_n <= 16'hFFFF;
                    if (wait_done) begin
                        link.device_select_n <= 1'b1;
                        busy_o    <= 1'b0;
                        done_o    <= 1'b1;
                        state_reg <= resolver_port_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= resolver_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ### shared/resolver_port_if.sv
// Pin bundle between the converter's host port and the host controller.
`timescale 1ns/1ps
`default_nettype none

interface resolver_port_if;
    logic        device_select_n;
    logic        read_strobe_n;
    logic        write_frame_strobe_n;
    logic        port_select;
    logic        sample_n;
    logic        mode_pin_lo;
    logic        mode_pin_hi;
    logic        resolution_select_lo;
    logic        resolution_select_hi;
    logic        enc_a;
    logic [15:0] dev_data_out;
    logic [15:0] dev_data_oe_n;
    logic [15:0] host_data_out;
    logic [15:0] host_data_oe_n;
    logic [15:0] data_bus;

    // Undriven lines read high, as a pull-up would leave them.
    assign data_bus = (~dev_data_oe_n & dev_data_out)
                    | (dev_data_oe_n & ~host_data_oe_n & host_data_out)
                    | (dev_data_oe_n & host_data_oe_n);

    modport device (
        input  device_select_n, read_strobe_n, write_frame_strobe_n, port_select,
        input  sample_n, mode_pin_lo, mode_pin_hi, resolution_select_lo,
        input  resolution_select_hi, data_bus,
        output dev_data_out, dev_data_oe_n, enc_a
    );

    modport host (
        output device_select_n, read_strobe_n, write_frame_strobe_n, port_select,
        output sample_n, mode_pin_lo, mode_pin_hi, resolution_select_lo,
        output resolution_select_hi, host_data_out, host_data_oe_n,
        input  data_bus, enc_a
    );
endinterface

`default_nettype wire

// ### shared/resolver_port_map.svh
// Timing counts, mode codes and frame sizes shared by both ends of the host port.
`ifndef RESOLVER_PORT_MAP_SVH
`define RESOLVER_PORT_MAP_SVH

`define RSP_CLK_NS          100
`define RSP_SETUP_NS        400
`define RSP_ACCESS_NS       800
`define RSP_SCLK_HALF_NS    1000
`define RSP_RELEASE_NS      400
`define RSP_SAMPLE_NS       400
`define RSP_SETUP_CYC       ((`RSP_SETUP_NS + `RSP_CLK_NS - 1) / `RSP_CLK_NS)
`define RSP_ACCESS_CYC      ((`RSP_ACCESS_NS + `RSP_CLK_NS - 1) / `RSP_CLK_NS)
`define RSP_SCLK_HALF_CYC   ((`RSP_SCLK_HALF_NS + `RSP_CLK_NS - 1) / `RSP_CLK_NS)
`define RSP_RELEASE_CYC     ((`RSP_RELEASE_NS + `RSP_CLK_NS - 1) / `RSP_CLK_NS)
`define RSP_SAMPLE_CYC      ((`RSP_SAMPLE_NS + `RSP_CLK_NS - 1) / `RSP_CLK_NS)

`define RSP_MODE_POSITION   2'h0
`define RSP_MODE_VELOCITY   2'h2
`define RSP_MODE_CONFIG     2'h3

`define RSP_DATA_BITS       16
`define RSP_FAULT_BITS      8
`define RSP_FRAME_BITS      24
`define RSP_CFG_BITS        8

`endif

// ### shared/resolver_port_pkg.sv
// Types used by the host end of the port and by the bench.
package resolver_port_pkg;

    typedef enum logic [1:0] {
        CMD_PAR_READ,
        CMD_PAR_WRITE,
        CMD_SERIAL
    } cmd_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_ACCESS,
        ST_RISE,
        ST_FALL,
        ST_RELEASE
    } host_state_t;

endpackage

// ### verif/resolver_port_sva.sv
// Pin-level assertions on the link between the converter port and its host.
`timescale 1ns/1ps
`default_nettype none
module resolver_port_sva (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        device_select_n,
    input wire logic        read_strobe_n,
    input wire logic        write_frame_strobe_n,
    input wire logic        port_select,
    input wire logic        mode_pin_lo,
    input wire logic        mode_pin_hi,
    input wire logic [15:0] dev_data_out,
    input wire logic [15:0] dev_data_oe_n,
    input wire logic [15:0] host_data_oe_n,
    input wire logic [15:0] data_bus
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////////////
    a_desel_release: assert property (device_select_n [*4] |-> &dev_data_oe_n)
        else $error("pin driven while deselected");
    a_idle_read_quiet: assert property ((port_select && read_strobe_n) [*4]
        |-> &dev_data_oe_n)
        else $error("pin driven without read strobe");
    a_read_drive_start: assert property ($fell(dev_data_oe_n[15]) && port_select
        |-> !device_select_n && !read_strobe_n)
        else $error("parallel drive without select and read");
    a_frame_drive_start: assert property ($fell(dev_data_oe_n[15]) && !port_select
        |-> !device_select_n && !write_frame_strobe_n)
        else $error("serial drive outside a frame");
    a_serial_one_pin: assert property (!port_select |-> dev_data_oe_n[14:0] == 15'h7FFF)
        else $error("serial mode drives a shared pin");
    // Output changes may lag the clock rise by the pin synchronisers, never lead it.
    a_sdo_on_rise: assert property (!port_select && $past(!dev_data_oe_n[15])
        && !dev_data_oe_n[15] && $changed(dev_data_out[15]) |-> $past(data_bus[13], 3))
        else $error("serial output moved off a clock rise");
    a_read_strobe_idle: assert property (!port_select |-> read_strobe_n)
        else $error("read strobe low in serial mode");
    a_host_clock_pin: assert property (!port_select && !write_frame_strobe_n
        |-> !host_data_oe_n[13])
        else $error("host not driving serial clock");
    a_write_low_byte: assert property (port_select && !write_frame_strobe_n
        |-> host_data_oe_n == 16'hFF00)
        else $error("parallel write not on low byte");
    a_mode_held: assert property (!port_select && !write_frame_strobe_n
        |-> $stable(mode_pin_lo) && $stable(mode_pin_hi))
        else $error("mode pins moved in a frame");
    c_par_read: cover property ((port_select && !read_strobe_n) [*8]);
    c_par_write: cover property (port_select && !write_frame_strobe_n);
    c_serial_end: cover property ($rose(dev_data_oe_n[15]) && !port_select);
endmodule
`default_nettype wire

// ### verif/test_resolver_converter_host_port.sv
// Self-checking bench joining the converter port and its host over the pin bundle.
`timescale 1ns/1ps
`default_nettype none
module test_resolver_converter_host_port;
    logic        clk_i, reset_i, start_i, sample_i, psel, valid_in, wf, enc, done, cfg_v, busy;
    logic [1:0]  mode, res, res_o;
    logic [7:0]  wdata, flt, cfg_o;
    logic [15:0] pos, vel, seed;
    logic [23:0] rdata;
    resolver_port_pkg::cmd_kind_t kind;
    int          bad_count, comparisons, pos_m, vel_m, flt_m, cfg_m, enc_m, i, g, cfg_pulses;
    resolver_port_if link();
    resolver_port_device i_resolver_port_device (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
        .link(link), .position_i(pos), .velocity_i(vel), .fault_i(flt),
        .signals_valid_i(valid_in), .config_data_o(cfg_o), .config_valid_o(cfg_v),
        .resolution_o(res_o));
    resolver_port_host i_resolver_port_host (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
        .link(link), .port_select_i(psel), .resolution_i(res), .start_i(start_i),
        .kind_i(kind), .mode_i(mode), .wdata_i(wdata), .with_fault_i(wf),
        .sample_i(sample_i), .busy_o(busy), .done_o(done), .rdata_o(rdata));
    resolver_port_sva i_sva (.clk_i(clk_i), .reset_i(reset_i),
        .device_select_n(link.device_select_n), .read_strobe_n(link.read_strobe_n),
        .write_frame_strobe_n(link.write_frame_strobe_n), .port_select(link.port_select),
        .mode_pin_lo(link.mode_pin_lo), .mode_pin_hi(link.mode_pin_hi),
        .dev_data_out(link.dev_data_out), .dev_data_oe_n(link.dev_data_oe_n),
        .host_data_oe_n(link.host_data_oe_n), .data_bus(link.data_bus));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    function automatic logic [15:0] word_m(input logic [1:0] m);
        return (m == 2'h2) ? 16'(vel_m) : (m == 2'h3) ? 16'(cfg_m) : 16'(pos_m);
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Settling gap after each transfer so port select never moves under a driven pin.
    task automatic xfer(input resolver_port_pkg::cmd_kind_t k, input logic [1:0] m,
                        input logic w, input logic [7:0] d);
        int t;
        kind = k;
        mode = m;
        wf = w;
        wdata = d;
        start_i = 1'b1;
        cycles(1);
        start_i = 1'b0;
        check({23'h0, busy}, 24'h000001);
        for (t = 0; t < 2000 && done !== 1'b1; t++) cycles(1);
        if (done !== 1'b1) bad_count++;
        cycles(8);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #1_000_000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        {reset_i, psel, start_i, sample_i, valid_in, wf, mode, res, wdata} = 18'h30000;
        kind = resolver_port_pkg::CMD_PAR_READ;
        {pos, vel, flt, seed, enc_m} = {40'h0, 16'h004F, 32'h0};
        cycles(8);
        reset_i = 1'b0;
        for (i = 0; i < 4; i++) begin
            valid_in = i[0];
            res = 2'(i);
            psel = 1'b1;
            cycles(4);
            sample_i = 1'b1;
            cycles(1);
            sample_i = 1'b0;
            cycles(12);
            {pos_m, vel_m, flt_m} = {16'h0, pos, 16'h0, vel, 24'h0, flt};
            {pos, vel, flt} = {rnd(), rnd(), 8'(rnd())};
            cfg_m = 32'(rnd() & 16'h00FF);
            xfer(resolver_port_pkg::CMD_PAR_WRITE, 2'(i), 1'b0, 8'(cfg_m));
            check({16'h0, cfg_o}, 24'(cfg_m));
            xfer(resolver_port_pkg::CMD_PAR_READ, 2'(i ^ (i >> 1)), 1'b0, 8'h00);
            check(rdata, {8'h00, word_m(2'(i ^ (i >> 1)))});
            psel = 1'b0;
            cycles(4);
            xfer(resolver_port_pkg::CMD_SERIAL, 2'(i ^ (i >> 1)), i[0], 8'(rnd()));
            g = i ^ (i >> 1);
            check(rdata, i[0] ? {word_m(2'(g)), 8'(flt_m)} : 24'(word_m(2'(g))));
            check({22'h0, res_o}, 24'(i & 3));
            check({23'h0, enc}, 24'(valid_in ? pos[1] : enc_m[0]));
            if (valid_in) enc_m = 32'(pos[1]);
        end
        // One configuration pulse per parallel write and one per serial frame.
        check(24'(cfg_pulses), 24'h000008);
        report_and_stop();
    end
    assign enc = link.enc_a;
    always @(posedge clk_i) if (cfg_v === 1'b1) cfg_pulses++;
endmodule
`default_nettype wire
